// *** design/arg_ground_irq.sv ***
`timescale 1ns/100ps
`include "arg_params.svh"
// What this block does
// R1: the ground switch follows config bit 7 and mode bit 6.
// R2: with the enable bit clear the switch pin floats.
// R3: enable set and resistance select clear ties the pin straight to ground.
// R4: both bits set connect the pin to ground through 20 kOhm.
// R5: status bits 8 to 15 are flags and never raise the interrupt.
// R6: status bits 0 to 7 are ORed into one converter interrupt.
// R7: each low status bit is gated by its own mask bit first.
// R8: a mask bit of 1 enables its source and the mask resets to zero.
// R9: software reads the status register to find the interrupt source.
// R10: reading the current result clears all result ready bits.
// R11: with the current channel off, voltage or temperature reads clear all.
// R12: software should read voltage first and current second.
// R13: a channel result is not reloaded while its ready bit is set.
// R14: while the core is powered down every enabled channel's result is stored regardless.
// R15: bits 0 to 2 flag ready results and are also set on calibration end.
// R16: the interrupt is a level held while an unmasked low bit is set.
module arg_ground_irq
    import arg_pkg::*;
#(
    parameter int RES_W = 16
) (
    // clock and reset
    input  wire logic             ref_clk_in,
    input  wire logic             rst_in,
    // apb slave
    input  wire logic             psel_in,
    input  wire logic             penable_in,
    input  wire logic             pwrite_in,
    input  wire logic [11:0]      paddr_in,
    input  wire logic [31:0]      pwdata_in,
    output logic      [31:0]      prdata_out,
    output logic                  pready_out,
    output logic                  pslverr_out,
    // conversion results from the filters
    input  wire logic [2:0]       result_valid_in,
    input  wire logic [2:0][RES_W-1:0] result_data_in,
    input  wire logic [2:0]       result_range_err_in,
    input  wire logic             cal_done_in,
    input  wire logic             core_powered_down_in,
    input  wire logic [4:3]       aux_event_in,
    // ground switch pin and interrupt
    output logic                  ground_switch_en_out,
    output logic                  ground_switch_res_out,
    output arg_gnd_e              ground_switch_mode_out,
    output logic                  converter_irq_out
);

    // =========================================================
    // state registers
    arg_state_s st;
    arg_state_s next_st;

    logic        access;
    logic        wr;
    logic        rd;
    logic        hit;
    logic [2:0]  load;
    logic [15:0] wmask;

    assign access = psel_in && penable_in;
    assign wr = access && pwrite_in;
    assign rd = access && !pwrite_in;

    // =========================================================
    // next state: bus writes, read side effects, result loading
    always_comb begin
        next_st = st;
        hit = 1'b1;
        wmask = 16'h0000;
        load = 3'b000;
        next_st.rdata = st.rdata;
        // read mux with side effects on result registers
        if (rd) begin
            unique case (paddr_in)
                `ARG_OFS_STATUS:  next_st.rdata = {16'h0000, st.status};
                `ARG_OFS_MASK:    next_st.rdata = {24'h00_0000, st.mask};
                `ARG_OFS_MODE:    next_st.rdata = {24'h00_0000, st.mode};
                `ARG_OFS_CONFIG:  next_st.rdata = {24'h00_0000, st.config_r};
                `ARG_OFS_CURRENT: next_st.rdata = {16'h0000, st.result[0]};
                `ARG_OFS_VOLTAGE: next_st.rdata = {16'h0000, st.result[1]};
                `ARG_OFS_TEMPER:  next_st.rdata = {16'h0000, st.result[2]};
                `ARG_OFS_CONTROL: next_st.rdata = {29'h0000_0000, st.chan_en};
                default: begin
                    next_st.rdata = 32'h0000_0000;
                    hit = 1'b0;
                end
            endcase
        end else if (wr) begin
            unique case (paddr_in)
                `ARG_OFS_STATUS: wmask = pwdata_in[15:0];
                `ARG_OFS_MASK:   next_st.mask = pwdata_in[7:0];
                `ARG_OFS_MODE:   next_st.mode = pwdata_in[7:0];
                `ARG_OFS_CONFIG: next_st.config_r = pwdata_in[7:0];
                `ARG_OFS_CONTROL: next_st.chan_en = pwdata_in[2:0];
                `ARG_OFS_CURRENT, `ARG_OFS_VOLTAGE, `ARG_OFS_TEMPER: ;
                default: hit = 1'b0;
            endcase
        end
        // write one to clear on sticky status bits
        next_st.status = st.status & ~wmask;
        if (wr && paddr_in == `ARG_OFS_MODE) begin
            next_st.status[`ARG_ST_CAL_DONE] = 1'b0;
        end
        // a current read clears every ready bit
        if (rd && paddr_in == `ARG_OFS_CURRENT) begin // [R10]
            next_st.status[2:0] = 3'b000;
        end
        // with current channel off, v or t reads also clear all
        if (rd && !st.chan_en[`ARG_CTL_CUR_EN] &&
            (paddr_in == `ARG_OFS_VOLTAGE ||
             paddr_in == `ARG_OFS_TEMPER)) begin // [R11]
            next_st.status[2:0] = 3'b000;
        end
        // results held while ready, unless the core sleeps
        for (int i = 0; i < 3; i++) begin
            load[i] = result_valid_in[i] && st.chan_en[i] &&
                      (!st.status[i] || core_powered_down_in); // [R13] [R14]
            if (load[i]) begin
                next_st.result[i] = result_data_in[i];
                next_st.status[i] = 1'b1; // [R15]
                next_st.status[`ARG_ST_CUR_ERR + i] = result_range_err_in[i];
            end
        end
        // hardware sets beat software clears
        if (cal_done_in) begin
            next_st.status[2:0] = 3'b111; // [R15]
            next_st.status[`ARG_ST_CAL_DONE] = 1'b1;
        end
        next_st.status[4:3] = next_st.status[4:3] | aux_event_in;
        next_st.status[11:5] = 7'h00;
    end

    // =========================================================
    // state register
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st.status   <= `ARG_RST_STATUS;
            st.mask     <= `ARG_RST_MASK; // [R8]
            st.mode     <= `ARG_RST_BYTE;
            st.config_r <= `ARG_RST_BYTE;
            st.chan_en  <= `ARG_RST_CTL;
            st.result   <= {3{`ARG_RST_RESULT}};
            st.rdata    <= 32'h0000_0000;
        end else begin
            st <= next_st;
        end
    end

    // =========================================================
    // apb answer: zero wait states, error on unmapped address
    assign pready_out  = 1'b1;
    assign pslverr_out = access && !hit;
    assign prdata_out  = next_st.rdata;

    // =========================================================
    // ground switch and interrupt outputs
    assign ground_switch_en_out  = st.config_r[`ARG_CFG_GND_EN]; // [R1]
    assign ground_switch_res_out = st.mode[`ARG_MDE_GND_RES]; // [R1]
    always_comb begin
        if (!ground_switch_en_out) begin
            ground_switch_mode_out = ARG_GND_FLOAT; // [R2]
        end else if (!ground_switch_res_out) begin
            ground_switch_mode_out = ARG_GND_DIRECT; // [R3]
        end else begin
            ground_switch_mode_out = ARG_GND_RESIST; // [R4]
        end
    end
    // only the low byte is masked in; the high byte is flags only, so a
    // range error or calibration flag never interrupts the core [R5] [R6]
    assign converter_irq_out = |(st.status[7:0] & st.mask); // [R7] [R16]

    // =========================================================
    // assertions and covers
    // every check lives in the one clock domain; reset masks them all
    default clocking chk_cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    // interrupt level tracks the masked low byte
    irq_level_a: assert property ( // [R16]
        converter_irq_out == |(st.status[7:0] & st.mask))
        else $error("irq level wrong");

    // a change in the high flags alone never moves the interrupt
    irq_high_only_a: assert property ( // [R5]
        $stable(st.status[7:0]) && $stable(st.mask)
        |-> $stable(converter_irq_out))
        else $error("high flags moved irq");

    // an all-zero mask keeps the interrupt quiet
    irq_mask_a: assert property ( // [R8]
        st.mask == 8'h00 |-> !converter_irq_out)
        else $error("irq with empty mask");

    // exactly one connection mode at any time
    gnd_onehot_a: assert property ( // [R1]
        $onehot(ground_switch_mode_out))
        else $error("ground mode not one-hot");

    // enable clear floats the pin whatever the resistance select says
    gnd_float_a: assert property ( // [R2]
        !st.config_r[`ARG_CFG_GND_EN]
        |-> ground_switch_mode_out == ARG_GND_FLOAT)
        else $error("ground not floating");

    // enable with select clear is a hard tie to ground
    gnd_direct_a: assert property ( // [R3]
        st.config_r[`ARG_CFG_GND_EN] && !st.mode[`ARG_MDE_GND_RES]
        |-> ground_switch_mode_out == ARG_GND_DIRECT)
        else $error("ground not direct");

    // both bits set route the pin through the resistor
    gnd_resist_a: assert property ( // [R4]
        st.config_r[`ARG_CFG_GND_EN] && st.mode[`ARG_MDE_GND_RES]
        |-> ground_switch_mode_out == ARG_GND_RESIST)
        else $error("ground not resistive");

    // a current read clears every ready bit when no set competes
    cur_read_clr_a: assert property ( // [R10]
        rd && paddr_in == `ARG_OFS_CURRENT && !cal_done_in && ~|result_valid_in
        |=> st.status[2:0] == 3'b000)
        else $error("current read did not clear ready");

    // current channel off: a voltage read clears all ready bits
    vt_read_clr_a: assert property ( // [R11]
        rd && !st.chan_en[0] && paddr_in == `ARG_OFS_VOLTAGE && !cal_done_in
        && ~|result_valid_in |=> st.status[2:0] == 3'b000)
        else $error("voltage read did not clear ready");

    // current channel off: a temperature read clears all ready bits
    tmp_read_clr_a: assert property ( // [R11]
        rd && !st.chan_en[0] && paddr_in == `ARG_OFS_TEMPER && !cal_done_in
        && ~|result_valid_in |=> st.status[2:0] == 3'b000)
        else $error("temperature read did not clear ready");

    // end of calibration raises all three ready bits and its own flag
    cal_ready_a: assert property ( // [R15]
        cal_done_in |=> st.status[2:0] == 3'b111 && st.status[15])
        else $error("calibration end not flagged");

    // a mode write drops the calibration flag unless a new one lands
    mode_cal_clr_a: assert property (
        wr && paddr_in == `ARG_OFS_MODE && !cal_done_in
        |=> !st.status[`ARG_ST_CAL_DONE])
        else $error("mode write kept calibration flag");

    // reserved status bits always read as zero
    reserved_zero_a: assert property (
        st.status[11:5] == 7'h00)
        else $error("reserved status bits set");

    // the voltage result is held while its ready bit is set and the core is awake
    hold_result_a: assert property ( // [R13]
        st.status[1] && !core_powered_down_in |=> $stable(st.result[1]))
        else $error("result overwritten while ready");

    // with the core asleep a new voltage result lands regardless
    sleep_load_a: assert property ( // [R14]
        result_valid_in[1] && st.chan_en[1] && core_powered_down_in
        |=> st.result[1] == $past(result_data_in[1]) && st.status[1])
        else $error("sleep result not stored");

    // the first edge out of reset finds every source masked off
    mask_reset_a: assert property ( // [R8]
        $fell(rst_in) |-> st.mask == `ARG_RST_MASK && !converter_irq_out)
        else $error("mask not cleared by reset");

    // per channel: a free ready bit takes the result and its error flag
    for (genvar c = 0; c < 3; c++) begin : g_chan_chk
        load_take_a: assert property ( // [R15]
            result_valid_in[c] && st.chan_en[c] && !st.status[c]
            |=> st.status[c] && st.result[c] == $past(result_data_in[c]))
            else $error("free channel did not take its result");
        err_follow_a: assert property (
            result_valid_in[c] && st.chan_en[c] && !st.status[c]
            |=> st.status[`ARG_ST_CUR_ERR + c] == $past(result_range_err_in[c]))
            else $error("range flag did not follow the result");
        chan_hold_a: assert property ( // [R13]
            st.status[c] && !core_powered_down_in |=> $stable(st.result[c]))
            else $error("held result was overwritten");
    end

    // main scenarios worth seeing at least once
    irq_seen_c: cover property (
        $rose(converter_irq_out));
    sleep_load_c: cover property (
        load[0] && st.status[0]);
    gnd_resist_c: cover property (
        ground_switch_mode_out == ARG_GND_RESIST);
    cal_seen_c: cover property (
        cal_done_in);
    vt_clear_c: cover property (
        rd && !st.chan_en[0] && paddr_in == `ARG_OFS_TEMPER);
endmodule : arg_ground_irq

// *** design/arg_params.svh ***
`ifndef ARG_PARAMS_SVH
`define ARG_PARAMS_SVH
// register byte offsets on the apb bus
`define ARG_OFS_STATUS   12'h000
`define ARG_OFS_MASK     12'h004
`define ARG_OFS_MODE     12'h008
`define ARG_OFS_CONFIG   12'h00C
`define ARG_OFS_CURRENT  12'h010
`define ARG_OFS_VOLTAGE  12'h014
`define ARG_OFS_TEMPER   12'h018
`define ARG_OFS_CONTROL  12'h01C
// field positions
`define ARG_CFG_GND_EN   7
`define ARG_MDE_GND_RES  6
`define ARG_CTL_CUR_EN   0
`define ARG_CTL_VOL_EN   1
`define ARG_CTL_TMP_EN   2
`define ARG_ST_CAL_DONE  15
`define ARG_ST_TMP_ERR   14
`define ARG_ST_VOL_ERR   13
`define ARG_ST_CUR_ERR   12
// reset values
`define ARG_RST_MASK     8'h00
`define ARG_RST_BYTE     8'h00
`define ARG_RST_CTL      3'h7
`define ARG_RST_STATUS   16'h0000
`define ARG_RST_RESULT   16'h0000
`endif

// *** design/arg_pkg.sv ***
package arg_pkg;
    // ground switch pin connection modes
    typedef enum logic [2:0] {
        ARG_GND_FLOAT  = 3'b001,
        ARG_GND_DIRECT = 3'b010,
        ARG_GND_RESIST = 3'b100
    } arg_gnd_e;

    // whole state of the block
    typedef struct packed {
        logic [15:0]      status;
        logic [7:0]       mask;
        logic [7:0]       mode;
        logic [7:0]       config_r;
        logic [2:0]       chan_en;
        logic [2:0][15:0] result;
        logic [31:0]      rdata;
    } arg_state_s;
endpackage : arg_pkg

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`include "arg_params.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module testbench;
    import arg_pkg::*;
    // ==========================================
    // stimulus and observed signals
    logic             ref_clk_in = 0;
    logic             rst_in = 1;
    logic             psel_in = 0;
    logic             penable_in = 0;
    logic             pwrite_in = 0;
    logic [11:0]      paddr_in = '0;
    logic [31:0]      pwdata_in = '0;
    logic [31:0]      prdata_out;
    logic             pready_out;
    logic             pslverr_out;
    logic [2:0]       result_valid_in = '0;
    logic [2:0][15:0] result_data_in = '0;
    logic [2:0]       result_range_err_in = '0;
    logic             cal_done_in = 0;
    logic             core_powered_down_in = 0;
    logic [4:3]       aux_event_in = '0;
    logic             ground_switch_en_out;
    logic             ground_switch_res_out;
    arg_gnd_e         ground_switch_mode_out;
    logic             converter_irq_out;
    logic             err;
    logic [31:0]      r;
    int               fails = 0;
    int               tests_run = 0;
    // 25 MHz clock
    always #20 ref_clk_in = ~ref_clk_in;
    arg_ground_irq arg_ground_irq_i (.*);
    // ==========================================
    // apb master: setup, then access held until pready is seen
    task automatic apb(input w, input [11:0] a, input [31:0] d);
        @(posedge ref_clk_in);
        psel_in   <= 1;
        pwrite_in <= w;
        paddr_in  <= a;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1;
        // the answer stands all through the access cycle: look mid-cycle
        @(negedge ref_clk_in);
        while (pready_out !== 1'b1) begin
            @(posedge ref_clk_in);
            @(negedge ref_clk_in);
        end
        r   = prdata_out;
        err = pslverr_out;
        @(posedge ref_clk_in);
        psel_in    <= 0;
        penable_in <= 0;
        #1; // let the write edge settle before outputs are judged
    endtask : apb
    // one-cycle event pulses on the filter side
    task automatic pulse(input [2:0] v, input [15:0] d, input c,
                         input [4:3] x);
        @(posedge ref_clk_in);
        result_valid_in <= v;
        result_data_in  <= {d, d, d};
        result_range_err_in <= v & {2'b00, d[15]};
        cal_done_in     <= c;
        aux_event_in    <= x;
        @(posedge ref_clk_in);
        result_valid_in <= '0;
        cal_done_in     <= 0;
        aux_event_in    <= '0;
        #1;
    endtask : pulse
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // watchdog: the tests need well under 1000 cycles
    initial begin
        #200000;
        fails++;
        print_verdict();
    end
    // ==========================================
    // test sequence
    initial begin
        repeat (16) @(posedge ref_clk_in);
        rst_in <= 0;
        apb(0, `ARG_OFS_MASK, 0);
        `CHK(r[7:0], 8'h00)
        `CHK(ground_switch_mode_out, ARG_GND_FLOAT)
        // all four switch combinations
        for (int i = 0; i < 4; i++) begin
            apb(1, `ARG_OFS_CONFIG, 32'(i[1]) << 7);
            apb(1, `ARG_OFS_MODE, 32'(i[0]) << 6);
            `CHK(ground_switch_en_out, i[1])
            `CHK(ground_switch_res_out, i[0])
            `CHK(ground_switch_mode_out, !i[1] ? ARG_GND_FLOAT : i[0] ?
                 ARG_GND_RESIST : ARG_GND_DIRECT)
        end
        // range error flag must not reach the interrupt
        pulse(3'b001, 16'h9234, 0, 0);
        apb(0, `ARG_OFS_STATUS, 0);
        `CHK(r, 32'h0000_1001)
        `CHK(converter_irq_out, 1'b0)
        apb(1, `ARG_OFS_MASK, 32'h0000_00fe);
        `CHK(converter_irq_out, 1'b0)
        apb(1, `ARG_OFS_MASK, 32'h0000_0001);
        `CHK(converter_irq_out, 1'b1)
        apb(0, `ARG_OFS_CURRENT, 0);
        `CHK(r[15:0], 16'h9234)
        apb(0, `ARG_OFS_STATUS, 0);
        `CHK(r, 32'h0000_1000)
        `CHK(converter_irq_out, 1'b0)
        apb(1, `ARG_OFS_MASK, 32'h0000_00ff);
        `CHK(converter_irq_out, 1'b0)
        // sticky events, cleared by writing ones
        pulse(3'b000, 0, 0, 2'b11);
        `CHK(converter_irq_out, 1'b1)
        apb(0, `ARG_OFS_STATUS, 0);
        `CHK(r, 32'h0000_1018)
        apb(1, `ARG_OFS_STATUS, 32'h0000_0018);
        `CHK(converter_irq_out, 1'b0)
        // a held ready bit blocks the second result
        pulse(3'b010, 16'h1111, 0, 0);
        pulse(3'b010, 16'h2222, 0, 0);
        apb(0, `ARG_OFS_VOLTAGE, 0);
        `CHK(r[15:0], 16'h1111)
        apb(0, `ARG_OFS_STATUS, 0);
        `CHK(r, 32'h0000_1002)
        // asleep core: enabled channel results always land
        core_powered_down_in <= 1;
        pulse(3'b010, 16'h3333, 0, 0);
        core_powered_down_in <= 0;
        apb(0, `ARG_OFS_VOLTAGE, 0);
        `CHK(r[15:0], 16'h3333)
        // current channel off: temperature read clears all
        apb(1, `ARG_OFS_CONTROL, 32'h0000_0006);
        apb(0, `ARG_OFS_TEMPER, 0);
        apb(0, `ARG_OFS_STATUS, 0);
        `CHK(r, 32'h0000_1000)
        pulse(3'b000, 0, 1, 0);
        apb(0, `ARG_OFS_STATUS, 0);
        `CHK(r, 32'h0000_9007)
        // paired read: voltage first, then current clears every ready bit
        apb(1, `ARG_OFS_CONTROL, 32'h0000_0007);
        apb(0, `ARG_OFS_VOLTAGE, 0);
        `CHK(r[15:0], 16'h3333)
        apb(0, `ARG_OFS_CURRENT, 0);
        apb(0, `ARG_OFS_STATUS, 0);
        `CHK(r, 32'h0000_9000)
        apb(0, 12'h020, 0);
        `CHK({err, r}, 33'h1_0000_0000)
        print_verdict();
    end
endmodule : testbench
